// ---- tccr_regs.sv ----
// Register bank of the common touch settings and coordinate transform
`timescale 1ns/10ps
// Summary of operation
// - Settings act alike for either engine
// - Coefficients A-F at 0x150..0x164 in order
// - Coefficients: sign, 15-bit integer, 16-bit fraction
// - Coefficient E resets to plus one
// - Coefficient F resets to zero
// - A resets to one; B,C,D to zero
// - Setup bit 15 reports engine kind, read only
// - Setup bit 14 selects host mode
// - Setup bit 12 ignores resistive short guard
// - Setup bit 11 enables low-power mode
// - Setup bits 10..4 hold module I2C address
// - Setup bit 2 skips 300ms start-up wait
// - Setup bits 1..0 pick resistive sampling clocks
// - Reserved setup bits read zero, no effect
module tccr_regs #(
    parameter int COORD_W        = 16,                         // Coordinate width
    parameter int STARTUP_CYCLES = tccr_pkg::STARTUP_CYCLES    // Start-up wait length
) (
    input  wire logic                       CLK,             // System clock
    input  wire logic                       RESET_N,         // Async reset, active low
    input  wire logic [tccr_pkg::ADDR_W-1:0] ADDR,           // Register byte address
    input  wire logic [31:0]                WDATA,           // Write data
    input  wire logic                       WR,              // Write strobe
    input  wire logic                       RD,              // Read strobe
    output logic      [31:0]                RDATA,           // Read data, cycle after RD
    input  wire logic                       ENGINE_RES,      // Strap: 1 resistive, 0 capacitive
    input  wire logic [COORD_W-1:0]         RAW_X,           // Raw touch x from engine
    input  wire logic [COORD_W-1:0]         RAW_Y,           // Raw touch y from engine
    output logic      [COORD_W-1:0]         SCREEN_X,        // Transformed x
    output logic      [COORD_W-1:0]         SCREEN_Y,        // Transformed y
    output logic                            HOST_MODE,       // Host mode selected
    output logic                            RES_NO_SHORT,    // Resistive short guard off
    output logic                            CAP_LOW_POWER,   // Capacitive low-power mode
    output logic      [6:0]                 CAP_I2C_ADDR,    // Capacitive module address
    output logic                            CAP_READY,       // Capacitive start-up done
    output logic      [1:0]                 RES_SAMPLE_CLKS  // Resistive sampling clocks
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);         // Wait counter width
    localparam int ADDR_W_L = tccr_pkg::ADDR_W;                // Local address width

    logic                   rst_m;                // Reset release first stage
    logic                   rst_n;                // Synchronised reset
    logic                   engine_res;           // Synchronised engine strap
    logic                   engine_kind;          // Strap caught after release
    logic                   kind_taken;           // Strap has been caught
    logic [31:0]            coeff [tccr_pkg::COEFF_NUM]; // Coefficients A..F
    logic [31:0]            setup;                // Writable setup bits
    logic [31:0]            next_rdata;           // Read mux result
    logic [ADDR_W_L-1:0]    idx;                  // Coefficient index
    logic                   in_coeff;             // Address hits a coefficient
    logic [COORD_W-1:0]     calc_x;               // Software test raw x
    logic [COORD_W-1:0]     calc_y;               // Software test raw y
    logic                   calc_sel;             // Use software input
    logic [COORD_W-1:0]     row_x;                // Transform row x
    logic [COORD_W-1:0]     row_y;                // Transform row y
    logic [CNT_W-1:0]       wait_cnt;             // Start-up counter

    initial begin
        if (COORD_W < 2 || COORD_W > 16) $error("tccr_regs: COORD_W out of range");
        if (STARTUP_CYCLES < 1) $error("tccr_regs: STARTUP_CYCLES must be positive");
    end

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    // Async assert, sync release of the internal reset
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // Engine strap crosses in through two flops
    tccr_sync u_sync_kind (
        .clk     (CLK),
        .reset_n (RESET_N),
        .d       (ENGINE_RES),
        .q       (engine_res)
    );

    // Catch the engine kind once after release, then hold it
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            engine_kind <= 1'b0;
            kind_taken  <= 1'b0;
        end else if (!kind_taken) begin
            engine_kind <= engine_res;
            kind_taken  <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Word index from the coefficient base
    always_comb begin
        idx      = (ADDR - tccr_pkg::OFF_COEFF_A) >> tccr_pkg::WORD_SHIFT;
        in_coeff = (ADDR >= tccr_pkg::OFF_COEFF_A) && (ADDR <= tccr_pkg::OFF_COEFF_F)
                   && (ADDR[1:0] == 2'b00);
    end

    // ------------------------------------------------------------------
    // Coefficient registers
    // ------------------------------------------------------------------
    // All 32 bits writable; A and E reset to one
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            coeff[0] <= tccr_pkg::COEFF_ONE;
            coeff[1] <= tccr_pkg::COEFF_ZERO;
            coeff[2] <= tccr_pkg::COEFF_ZERO;
            coeff[3] <= tccr_pkg::COEFF_ZERO;
            coeff[4] <= tccr_pkg::COEFF_ONE;
            coeff[5] <= tccr_pkg::COEFF_ZERO;
        end else if (WR && in_coeff) begin
            coeff[idx[2:0]] <= WDATA;
        end
    end

    // ------------------------------------------------------------------
    // Setup register
    // ------------------------------------------------------------------
    // Only writable fields kept; reserved and read-only bits drop
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            setup <= tccr_pkg::SETUP_RESET;
        end else if (WR && ADDR == tccr_pkg::OFF_SETUP) begin
            setup <= WDATA & tccr_pkg::SETUP_WMASK;
        end
    end

    // Software test input for the transform
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            calc_x   <= '0;
            calc_y   <= '0;
            calc_sel <= 1'b0;
        end else if (WR && ADDR == tccr_pkg::OFF_CALC_IN) begin
            calc_x   <= WDATA[COORD_W-1:0];
            calc_y   <= WDATA[16 +: COORD_W];
            calc_sel <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Mux of readable words; unmapped reads zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (in_coeff) begin
            next_rdata = coeff[idx[2:0]];
        end else if (ADDR == tccr_pkg::OFF_SETUP) begin
            next_rdata = setup;
            next_rdata[tccr_pkg::BIT_MODE_RES] = engine_kind;
        end else if (ADDR == tccr_pkg::OFF_CALC_OUT) begin
            next_rdata[COORD_W-1:0]  = row_x;
            next_rdata[16 +: COORD_W] = row_y;
        end
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Engine controls, same for either engine kind
    // ------------------------------------------------------------------
    // Fields fanned out to both engines from flops
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            HOST_MODE       <= 1'b0;
            RES_NO_SHORT    <= 1'b0;
            CAP_LOW_POWER   <= 1'b0;
            CAP_I2C_ADDR    <= 7'h00;
            RES_SAMPLE_CLKS <= 2'h0;
        end else begin
            HOST_MODE       <= setup[tccr_pkg::BIT_HOST_MODE];
            RES_NO_SHORT    <= setup[tccr_pkg::BIT_NO_SHORT];
            CAP_LOW_POWER   <= setup[tccr_pkg::BIT_LOW_POWER];
            CAP_I2C_ADDR    <= setup[tccr_pkg::ADDR_MSB:tccr_pkg::ADDR_LSB];
            RES_SAMPLE_CLKS <= setup[tccr_pkg::SAMP_MSB:tccr_pkg::SAMP_LSB];
        end
    end

    // ------------------------------------------------------------------
    // Capacitive start-up wait
    // ------------------------------------------------------------------
    // Count out the wait unless suppressed
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt  <= '0;
            CAP_READY <= 1'b0;
        end else if (setup[tccr_pkg::BIT_NO_STARTUP]) begin
            CAP_READY <= 1'b1;
        end else if (wait_cnt == CNT_W'(STARTUP_CYCLES - 1)) begin
            CAP_READY <= 1'b1;
        end else begin
            wait_cnt  <= wait_cnt + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Affine transform
    // ------------------------------------------------------------------
    // Screen x from A, B, C
    tccr_affine #(.IN_W(COORD_W)) u_row_x (
        .clk     (CLK),
        .reset_n (rst_n),
        .x       (calc_sel ? calc_x : RAW_X),
        .y       (calc_sel ? calc_y : RAW_Y),
        .k0      (coeff[0]),
        .k1      (coeff[1]),
        .k2      (coeff[2]),
        .q       (row_x)
    );

    // Screen y from D, E, F
    tccr_affine #(.IN_W(COORD_W)) u_row_y (
        .clk     (CLK),
        .reset_n (rst_n),
        .x       (calc_sel ? calc_x : RAW_X),
        .y       (calc_sel ? calc_y : RAW_Y),
        .k0      (coeff[3]),
        .k1      (coeff[4]),
        .k2      (coeff[5]),
        .q       (row_y)
    );

    // Registered screen outputs
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SCREEN_X <= '0;
            SCREEN_Y <= '0;
        end else begin
            SCREEN_X <= row_x;
            SCREEN_Y <= row_y;
        end
    end
endmodule // tccr_regs

// ---- tccr_pkg.sv ----
// Package of offsets, field layouts, reset values and timing for the touch common register bank
package tccr_pkg;
    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_COEFF_A  = 12'h150;  // Coefficient A
    localparam logic [11:0] OFF_COEFF_B  = 12'h154;  // Coefficient B
    localparam logic [11:0] OFF_COEFF_C  = 12'h158;  // Coefficient C
    localparam logic [11:0] OFF_COEFF_D  = 12'h15C;  // Coefficient D
    localparam logic [11:0] OFF_COEFF_E  = 12'h160;  // Coefficient E
    localparam logic [11:0] OFF_COEFF_F  = 12'h164;  // Coefficient F
    localparam logic [11:0] OFF_SETUP    = 12'h168;  // Touch setup word
    localparam logic [11:0] OFF_CALC_IN  = 12'h170;  // Raw x,y test input
    localparam logic [11:0] OFF_CALC_OUT = 12'h174;  // Screen x,y result
    localparam int          ADDR_W       = 12;       // Address width
    localparam int          COEFF_NUM    = 6;        // Number of coefficients
    localparam int          WORD_SHIFT   = 2;        // Byte to word index shift

    // ------------------------------------------------------------------
    // Fixed-point layout of a coefficient
    // ------------------------------------------------------------------
    localparam int SIGN_BIT  = 31;  // Sign
    localparam int INT_MSB   = 30;  // Integer part top
    localparam int INT_LSB   = 16;  // Integer part bottom
    localparam int FRAC_BITS = 16;  // Fractional bits 15..0

    localparam logic [31:0] COEFF_ONE  = 32'h0001_0000;  // Plus one
    localparam logic [31:0] COEFF_ZERO = 32'h0000_0000;  // Plus zero

    // ------------------------------------------------------------------
    // Setup word fields
    // ------------------------------------------------------------------
    localparam int BIT_MODE_RES   = 15;  // Engine kind, read only
    localparam int BIT_HOST_MODE  = 14;  // Host mode select
    localparam int BIT_NO_SHORT   = 12;  // Ignore short-circuit guard
    localparam int BIT_LOW_POWER  = 11;  // Low-power enable
    localparam int ADDR_MSB       = 10;  // I2C address top
    localparam int ADDR_LSB       = 4;   // I2C address bottom
    localparam int BIT_NO_STARTUP = 2;   // Skip start-up wait
    localparam int SAMP_MSB       = 1;   // Sampling clocks top
    localparam int SAMP_LSB       = 0;   // Sampling clocks bottom
    // Writable bits of the setup word: 14, 12, 11, 10..4, 2, 1..0
    localparam logic [31:0] SETUP_WMASK = 32'h0000_5FF7;
    // Reset of the writable part, engine bit added at run time
    localparam logic [31:0] SETUP_RESET = 32'h0000_0381;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ       = 100;   // System clock rate
    localparam int STARTUP_MS    = 300;   // Capacitive module start-up wait
    localparam int STARTUP_CYCLES = STARTUP_MS * 1000 * CLK_MHZ;  // Microseconds times cycles per us
endpackage

// ---- tccr_sync.sv ----
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module tccr_sync (
    input  wire logic clk,       // Clock
    input  wire logic reset_n,   // Async reset, active low
    input  wire logic d,         // Asynchronous level
    output logic      q          // Synchronised level
);
    logic meta;                  // First stage, read only by q

    // Two stages, cleared on reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // tccr_sync

// ---- tccr_affine.sv ----
// One row of the affine transform: out = k0*x + k1*y + k2 in fixed point
`timescale 1ns/10ps
module tccr_affine #(
    parameter int IN_W = 16      // Width of signed raw coordinate
) (
    input  wire logic              clk,     // Clock
    input  wire logic              reset_n, // Synchronised reset, active low
    input  wire logic signed [IN_W-1:0] x,  // Raw x
    input  wire logic signed [IN_W-1:0] y,  // Raw y
    input  wire logic signed [31:0] k0,     // Weight on x
    input  wire logic signed [31:0] k1,     // Weight on y
    input  wire logic signed [31:0] k2,     // Offset
    output logic signed [IN_W-1:0] q        // Screen coordinate
);
    localparam int PW = 32 + IN_W + 2;      // Product and sum width
    logic signed [PW-1:0] sum;              // Full precision sum

    initial begin
        if (IN_W < 2 || IN_W > 32) $error("tccr_affine: IN_W out of range");
    end

    // Combined weighted sum at full width
    always_comb begin
        sum = PW'(k0 * x) + PW'(k1 * y) + PW'(k2);
    end

    // Drop the sixteen fraction bits, keep the low coordinate bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= sum[tccr_pkg::FRAC_BITS +: IN_W];
        end
    end
endmodule // tccr_affine

// ---- tccr_regs_assertions.sv ----
// Checker of the touch common register bank, bound to its top module
`timescale 1ns/10ps
module tccr_regs_checker #(
    parameter int COORD_W        = 16,     // Coordinate width
    parameter int STARTUP_CYCLES = 20      // Start-up wait length
) (
    input wire logic               CLK,             // System clock
    input wire logic               RESET_N,         // Reset, active low
    input wire logic [11:0]        ADDR,            // Byte address
    input wire logic [31:0]        WDATA,           // Write data
    input wire logic               WR,              // Write strobe
    input wire logic               RD,              // Read strobe
    input wire logic [31:0]        RDATA,           // Read data
    input wire logic               ENGINE_RES,      // Engine strap
    input wire logic [COORD_W-1:0] RAW_X,           // Raw x
    input wire logic [COORD_W-1:0] RAW_Y,           // Raw y
    input wire logic [COORD_W-1:0] SCREEN_X,        // Screen x
    input wire logic [COORD_W-1:0] SCREEN_Y,        // Screen y
    input wire logic               HOST_MODE,       // Host mode
    input wire logic               RES_NO_SHORT,    // Short guard off
    input wire logic               CAP_LOW_POWER,   // Low-power mode
    input wire logic [6:0]         CAP_I2C_ADDR,    // Module address
    input wire logic               CAP_READY,       // Start-up done
    input wire logic [1:0]         RES_SAMPLE_CLKS  // Sampling clocks
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [31:0] wdata_d1;   // Write data one cycle back
    logic [31:0] wdata_d2;   // Write data two cycles back
    logic [15:0] up_cnt;     // Cycles since reset release, saturating

    // Delay line of write data, so later checks see the written word
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wdata_d1 <= 32'h0000_0000;
            wdata_d2 <= 32'h0000_0000;
        end else begin
            wdata_d1 <= WDATA;
            wdata_d2 <= wdata_d1;
        end
    end

    // Counts up from reset release, stops at the top
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            up_cnt <= 16'h0000;
        end else if (up_cnt != 16'hFFFF) begin
            up_cnt <= up_cnt + 16'h0001;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    rdata_idle_a: assert property (!RD |=> RDATA == 32'h0000_0000)
        else $error("read data not zero outside a read");
    host_bits_a: assert property (WR && ADDR == tccr_pkg::OFF_SETUP |-> ##2
        {HOST_MODE, RES_NO_SHORT, CAP_LOW_POWER} == {wdata_d2[14], wdata_d2[12:11]})
        else $error("setup mode outputs do not follow write");
    field_copy_a: assert property (WR && ADDR == tccr_pkg::OFF_SETUP |-> ##2
        {CAP_I2C_ADDR, RES_SAMPLE_CLKS} == {wdata_d2[10:4], wdata_d2[1:0]})
        else $error("address or sampling field does not follow write");
    engine_kind_a: assert property (RD && ADDR == tccr_pkg::OFF_SETUP |=>
        RDATA[15] == ENGINE_RES)
        else $error("engine kind bit differs from strap");
    rsvd_zero_a: assert property (RD && ADDR == tccr_pkg::OFF_SETUP |=>
        RDATA[31:16] == 16'h0000 && !RDATA[13] && !RDATA[3])
        else $error("reserved setup bits not zero");
    unmapped_zero_a: assert property (RD && (ADDR < tccr_pkg::OFF_COEFF_A
        || ADDR > tccr_pkg::OFF_CALC_OUT || ADDR == 12'h16C) |=> RDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    fast_ready_a: assert property (WR && ADDR == tccr_pkg::OFF_SETUP && WDATA[2]
        |-> ##[1:3] CAP_READY)
        else $error("start-up skip did not raise ready");
    late_ready_a: assert property (up_cnt == STARTUP_CYCLES + 8 |-> CAP_READY)
        else $error("ready missing after start-up wait");
    coeff_back_a: assert property (WR && ADDR >= tccr_pkg::OFF_COEFF_A
        && ADDR <= tccr_pkg::OFF_COEFF_F && ADDR[1:0] == 2'h0 ##1 RD && ADDR == $past(ADDR)
        |=> RDATA == wdata_d2)
        else $error("coefficient read back differs from write");
endmodule // tccr_regs_checker

bind tccr_regs tccr_regs_checker #(.COORD_W(COORD_W), .STARTUP_CYCLES(STARTUP_CYCLES))
    i_tccr_regs_checker (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .ENGINE_RES(ENGINE_RES), .RAW_X(RAW_X), .RAW_Y(RAW_Y),
    .SCREEN_X(SCREEN_X), .SCREEN_Y(SCREEN_Y), .HOST_MODE(HOST_MODE),
    .RES_NO_SHORT(RES_NO_SHORT), .CAP_LOW_POWER(CAP_LOW_POWER),
    .CAP_I2C_ADDR(CAP_I2C_ADDR), .CAP_READY(CAP_READY), .RES_SAMPLE_CLKS(RES_SAMPLE_CLKS));

// ---- tccr_regs_test.sv ----
// Self-checking testbench of the touch common register bank
`timescale 1ns/10ps
module tccr_regs_test;
    localparam int SIM_WAIT = 200;                   // Shortened start-up wait
    logic        CLK        = 1'b0;                   // System clock
    logic        RESET_N    = 1'b0;                   // Reset, active low
    logic [11:0] ADDR       = 12'h000;                // Byte address
    logic [31:0] WDATA      = 32'h0000_0000;          // Write data
    logic        WR         = 1'b0;                   // Write strobe
    logic        RD         = 1'b0;                   // Read strobe
    logic        ENGINE_RES = 1'b1;                   // Strap, resistive first
    logic [15:0] RAW_X      = 16'h0064;               // Raw x of 100
    logic [15:0] RAW_Y      = 16'h0028;               // Raw y of 40
    logic [31:0] RDATA;                               // Read data
    logic [15:0] SCREEN_X, SCREEN_Y;                  // Transformed point
    logic        HOST_MODE, RES_NO_SHORT, CAP_LOW_POWER, CAP_READY; // Setup outputs
    logic [6:0]  CAP_I2C_ADDR;                        // Module address
    logic [1:0]  RES_SAMPLE_CLKS;                     // Sampling clocks
    int          failures = 0;                        // Mismatch count
    int          n_tests  = 0;                        // Comparison count
    logic [31:0] v, d;                                // Read and write words
    // Coefficients 2, 0.5, 5, 1, 3, 7: point (100,40) maps to (225,227)
    logic [31:0] ctab [6] = '{32'h0002_0000, 32'h0000_8000, 32'h0005_0000,
                              32'h0001_0000, 32'h0003_0000, 32'h0007_0000};

    // Free-running 100 MHz clock
    always #5 CLK = ~CLK;

    tccr_regs #(.COORD_W(16), .STARTUP_CYCLES(SIM_WAIT)) i_tccr_regs (
        .CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .ENGINE_RES(ENGINE_RES), .RAW_X(RAW_X), .RAW_Y(RAW_Y),
        .SCREEN_X(SCREEN_X), .SCREEN_Y(SCREEN_Y), .HOST_MODE(HOST_MODE),
        .RES_NO_SHORT(RES_NO_SHORT), .CAP_LOW_POWER(CAP_LOW_POWER),
        .CAP_I2C_ADDR(CAP_I2C_ADDR), .CAP_READY(CAP_READY), .RES_SAMPLE_CLKS(RES_SAMPLE_CLKS));

    // ------------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------------
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Counts line, verdict, end of run
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One-cycle write, then one idle cycle
    task automatic wr(input logic [11:0] a, input logic [31:0] w);
        ADDR <= a;
        WDATA <= w;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask

    // One-cycle read; data taken mid-way through the answer cycle
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        r = RDATA;
        @(posedge CLK);
    endtask

    // Write directly followed by a read of the same place
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] w, output logic [31:0] r);
        ADDR <= a;
        WDATA <= w;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        r = RDATA;
        @(posedge CLK);
    endtask

    // Reset held 16 cycles with the given strap, then settle time
    task automatic do_reset(input logic strap);
        RESET_N <= 1'b0;
        ENGINE_RES <= strap;
        repeat (16) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (6) @(posedge CLK);
    endtask

    // Load the coefficient table and look at the mapped point
    task automatic xform;
        for (int i = 0; i < 6; i++) wr(tccr_pkg::OFF_COEFF_A + 12'(4 * i), ctab[i]);
        repeat (4) @(posedge CLK);
        check({SCREEN_Y, SCREEN_X}, {16'd227, 16'd225});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        check(CAP_READY, 1'b0);
        check({HOST_MODE, RES_NO_SHORT, CAP_LOW_POWER}, 3'b000);
        check({CAP_I2C_ADDR, RES_SAMPLE_CLKS}, {7'h38, 2'h1});
        // Reset values, A and E are plus one
        for (int i = 0; i < 6; i++) begin
            rd(tccr_pkg::OFF_COEFF_A + 12'(4 * i), v);
            check(v, (i == 0 || i == 4) ? 32'h0001_0000 : 32'h0000_0000);
        end
        rd(tccr_pkg::OFF_SETUP, v);
        check(v, 32'h0000_8381);
        // Distinct signed words, then all read again for aliasing
        for (int i = 0; i < 6; i++) begin
            wr_rd(tccr_pkg::OFF_COEFF_A + 12'(4 * i), 32'h8123_4567 ^ (32'h0101_0101 * i), v);
            check(v, 32'h8123_4567 ^ (32'h0101_0101 * i));
        end
        for (int i = 0; i < 6; i++) begin
            rd(tccr_pkg::OFF_COEFF_A + 12'(4 * i), v);
            check(v, 32'h8123_4567 ^ (32'h0101_0101 * i));
        end
        // Every sampling code and both module addresses, reserved bits set
        for (int s = 0; s < 4; s++) begin
            d = {16'hFFFF, 1'b0, s[0], 1'b1, s[1], ~s[0], s[0] ? 7'h5D : 7'h38, 2'b10, 2'(s)};
            wr(tccr_pkg::OFF_SETUP, d);
            rd(tccr_pkg::OFF_SETUP, v);
            check(v, {16'h0000, ENGINE_RES, d[14], 1'b0, d[12:4], 1'b0, d[2:0]});
            check({HOST_MODE, RES_NO_SHORT, CAP_LOW_POWER}, {d[14], d[12:11]});
            check({CAP_I2C_ADDR, RES_SAMPLE_CLKS}, {d[10:4], d[1:0]});
        end
        xform();
        // Unmapped place takes nothing and reads zero
        wr(12'h16C, 32'hFFFF_FFFF);
        rd(12'h16C, v);
        check(v, 32'h0000_0000);
        rd(tccr_pkg::OFF_COEFF_F, v);
        check(v, 32'h0007_0000);
        rd(12'h200, v);
        check(v, 32'h0000_0000);
        // Bounded wait for the start-up delay to run out
        for (int n = 0; n < SIM_WAIT + 50 && CAP_READY !== 1'b1; n++) @(posedge CLK);
        check(CAP_READY, 1'b1);
        if (CAP_READY !== 1'b1) wrap_up();
        // Capacitive strap, start-up skipped, engine bit not writable
        do_reset(1'b0);
        wr(tccr_pkg::OFF_SETUP, 32'h0000_8384);
        @(negedge CLK);
        check(CAP_READY, 1'b1);
        @(posedge CLK);
        rd(tccr_pkg::OFF_SETUP, v);
        check(v, 32'h0000_0384);
        xform();
        // Software-driven point (20,10) maps to (50,57), unlike the pin point
        wr(tccr_pkg::OFF_CALC_IN, {16'd10, 16'd20});
        repeat (3) @(posedge CLK);
        rd(tccr_pkg::OFF_CALC_OUT, v);
        check(v, {16'd57, 16'd50});
        wrap_up();
    end
endmodule // tccr_regs_test
